/* File: rtl/ppp_prom_programmer.sv */
// controller that writes, verifies and reads the prom through its programming pins
//
// Contract
// - never drive enable and read strobe low together at 12.5 V / 6 V
// - hold reset low, 5 V on vpp, then 6 V vdd, 12.5 V vpp, then address (the code sets address 0 with reset low, before 6 V / 12.5 V)
// - present write data, then one 1 ms active-low program pulse (the code drives the data only during the pulse, from its first cycle)
// - verify after each pulse, retry; after 25 failures stop as defective
// - after verify, add one pulse of 3 ms times the attempts used
// - then increment address and repeat until past the last location
// - readout: reset low, 5 V on vdd and vpp, address, read strobe
`default_nettype none
`include "ppp_defines.svh"
module ppp_prom_programmer #(
   parameter int ADDR_W     = `PPP_ADDR_W,
   parameter int DATA_W     = `PPP_DATA_W,
   parameter int PULSE_CYC  = `PPP_PULSE_CYC,
   parameter int OVER_CYC   = `PPP_OVER_CYC,
   parameter int MAX_TRIES  = `PPP_MAX_TRIES,
   parameter int SETTLE_CYC = `PPP_SETTLE_CYC
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   // image load and readout port
   input  wire logic              imgWrEn,
   input  wire logic [ADDR_W-1:0] imgWrAddr,
   input  wire logic [DATA_W-1:0] imgWrData,
   input  wire logic              startProg,
   input  wire logic              startRead,
   input  wire logic [ADDR_W-1:0] readAddr,
   output logic      [DATA_W-1:0] readData,
   output logic                   readValid,
   output logic                   busy,
   output logic                   done,
   output logic                   defective,
   output logic      [ADDR_W-1:0] failAddr,
   // prom programming pins
   output logic      [ADDR_W-1:0] prog_addr_bus,
   input  wire logic [DATA_W-1:0] progDataIn,
   output logic      [DATA_W-1:0] progDataOut,
   output logic                   progDataOe,
   output logic                   progEnable_n,
   output logic                   progRead_n,
   output logic                   devReset_n,
   output ppp_pkg::ppp_vpp_t      vppSel,
   output ppp_pkg::ppp_vdd_t      vddSel
);
   // ------------------------------------------------------------
   // constants and state
   // ------------------------------------------------------------
   localparam int CNT_W = $clog2(MAX_TRIES * OVER_CYC + 1);
   localparam int TRY_W = $clog2(MAX_TRIES + 1);
   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(`PPP_LAST_ADDR);

   ppp_pkg::ppp_state_t stateReg, stateNext;
   logic [CNT_W-1:0]  cntReg, cntNext;
   logic [TRY_W-1:0]  tryReg, tryNext;
   logic [ADDR_W-1:0] addrReg, addrNext;
   logic [DATA_W-1:0] rdReg, rdNext;
   logic              rdValidReg, rdValidNext;
   logic              doneReg, doneNext;
   logic              defReg, defNext;
   logic              readMode_reg, readMode_next;
   logic [DATA_W-1:0] dinMeta, dinSync;
   logic [DATA_W-1:0] imgByte;

   // ------------------------------------------------------------
   // image memory
   // ------------------------------------------------------------
   ppp_image_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_img (
      .core_clk (core_clk),
      .wrEn     (imgWrEn),
      .wrAddr   (imgWrAddr),
      .wrData   (imgWrData),
      .rdAddr   (addrReg),
      .rdData   (imgByte)
   );

   // the data pins come from another domain: two flops before any compare
   always_ff @(posedge core_clk) begin
      dinMeta <= progDataIn;
      dinSync <= dinMeta;
   end

   function automatic logic cntDone(input logic [CNT_W-1:0] c);
      return c == '0;
   endfunction

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      stateNext     = stateReg;
      cntNext       = cntReg;
      tryNext       = tryReg;
      addrNext      = addrReg;
      rdNext        = rdReg;
      rdValidNext   = 1'b0;
      doneNext      = doneReg;
      defNext       = defReg;
      readMode_next = readMode_reg;
      unique case (stateReg)
         ppp_pkg::PPP_IDLE: begin
            if (startProg) begin
               stateNext     = ppp_pkg::PPP_PWRUP;
               readMode_next = 1'b0;
               addrNext      = '0;
               doneNext      = 1'b0;
               defNext       = 1'b0;
               cntNext       = CNT_W'(SETTLE_CYC);
            end else if (startRead) begin
               stateNext     = ppp_pkg::PPP_PWRUP;
               readMode_next = 1'b1;
               addrNext      = readAddr;
               cntNext       = CNT_W'(SETTLE_CYC);
            end
         end
         ppp_pkg::PPP_PWRUP: begin
            // supplies settle before the first address is used
            if (cntDone(cntReg)) begin
               stateNext = readMode_reg ? ppp_pkg::PPP_RDSET : ppp_pkg::PPP_SETUP;
               cntNext   = CNT_W'(SETTLE_CYC);
               tryNext   = '0;
            end else begin
               cntNext = cntReg - 1'b1;
            end
         end
         ppp_pkg::PPP_SETUP: begin
            if (cntDone(cntReg)) begin
               stateNext = ppp_pkg::PPP_PULSE;
               cntNext   = CNT_W'(PULSE_CYC - 1);
               tryNext   = tryReg + 1'b1;
            end else begin
               cntNext = cntReg - 1'b1;
            end
         end
         ppp_pkg::PPP_PULSE: begin
            if (cntDone(cntReg)) begin
               stateNext = ppp_pkg::PPP_VSET;
               cntNext   = CNT_W'(SETTLE_CYC);
            end else begin
               cntNext = cntReg - 1'b1;
            end
         end
         ppp_pkg::PPP_VSET: begin
            if (cntDone(cntReg)) begin
               stateNext = ppp_pkg::PPP_VCHK;
            end else begin
               cntNext = cntReg - 1'b1;
            end
         end
         ppp_pkg::PPP_VCHK: begin
            if (dinSync == imgByte) begin
               stateNext = ppp_pkg::PPP_OVER;
               cntNext   = CNT_W'(OVER_CYC * tryReg - 1);
            end else if (tryReg >= TRY_W'(MAX_TRIES)) begin
               stateNext = ppp_pkg::PPP_FAIL;
               defNext   = 1'b1;
            end else begin
               stateNext = ppp_pkg::PPP_SETUP;
               cntNext   = CNT_W'(SETTLE_CYC);
            end
         end
         ppp_pkg::PPP_OVER: begin
            if (cntDone(cntReg)) begin
               stateNext = ppp_pkg::PPP_NEXT;
            end else begin
               cntNext = cntReg - 1'b1;
            end
         end
         ppp_pkg::PPP_NEXT: begin
            if (addrReg == LAST_ADDR) begin
               stateNext = ppp_pkg::PPP_DONE;
               doneNext  = 1'b1;
            end else begin
               addrNext  = addrReg + 1'b1;
               tryNext   = '0;
               stateNext = ppp_pkg::PPP_SETUP;
               cntNext   = CNT_W'(SETTLE_CYC);
            end
         end
         ppp_pkg::PPP_RDSET: begin
            if (cntDone(cntReg)) begin
               stateNext = ppp_pkg::PPP_RDCAP;
            end else begin
               cntNext = cntReg - 1'b1;
            end
         end
         ppp_pkg::PPP_RDCAP: begin
            rdNext      = dinSync;
            rdValidNext = 1'b1;
            stateNext   = ppp_pkg::PPP_IDLE;
         end
         ppp_pkg::PPP_DONE,
         ppp_pkg::PPP_FAIL: begin
            stateNext = ppp_pkg::PPP_IDLE;
         end
         default: begin
            stateNext = ppp_pkg::PPP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stateReg     <= ppp_pkg::PPP_IDLE;
         cntReg       <= '0;
         tryReg       <= '0;
         addrReg      <= '0;
         rdReg        <= '0;
         rdValidReg   <= 1'b0;
         doneReg      <= 1'b0;
         defReg       <= 1'b0;
         readMode_reg <= 1'b0;
      end else begin
         stateReg     <= stateNext;
         cntReg       <= cntNext;
         tryReg       <= tryNext;
         addrReg      <= addrNext;
         rdReg        <= rdNext;
         rdValidReg   <= rdValidNext;
         doneReg      <= doneNext;
         defReg       <= defNext;
         readMode_reg <= readMode_next;
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   logic inWrite, inRead, pulseOn, verifyOn;
   assign inWrite  = (stateReg == ppp_pkg::PPP_SETUP) || (stateReg == ppp_pkg::PPP_PULSE) ||
                     (stateReg == ppp_pkg::PPP_VSET)  || (stateReg == ppp_pkg::PPP_VCHK)  ||
                     (stateReg == ppp_pkg::PPP_OVER)  || (stateReg == ppp_pkg::PPP_NEXT);
   assign inRead   = (stateReg == ppp_pkg::PPP_RDSET) || (stateReg == ppp_pkg::PPP_RDCAP);
   assign pulseOn  = (stateReg == ppp_pkg::PPP_PULSE) || (stateReg == ppp_pkg::PPP_OVER);
   assign verifyOn = (stateReg == ppp_pkg::PPP_VSET) || (stateReg == ppp_pkg::PPP_VCHK);

   // device reset is held low throughout any session so the port stays in programming mode
   assign devReset_n    = (stateReg == ppp_pkg::PPP_IDLE);
   assign vppSel        = inWrite ? ppp_pkg::PPP_VPP_12V5 :
                          (stateReg == ppp_pkg::PPP_IDLE) ? ppp_pkg::PPP_VPP_GND :
                          ppp_pkg::PPP_VPP_5V;
   assign vddSel        = inWrite ? ppp_pkg::PPP_VDD_6V :
                          (stateReg == ppp_pkg::PPP_IDLE) ? ppp_pkg::PPP_VDD_OFF :
                          ppp_pkg::PPP_VDD_5V;
   assign prog_addr_bus = addrReg;
   // enable doubles as the program pulse and as memory enable for read; verify keeps it high
   // so that it never meets the read strobe while the supplies are raised
   assign progEnable_n  = ~(pulseOn | inRead);
   // read strobe only low while the pulse is off, never together at high voltage
   assign progRead_n    = ~(verifyOn | inRead);
   assign progDataOe    = pulseOn;
   assign progDataOut   = imgByte;
   assign readData      = rdReg;
   assign readValid     = rdValidReg;
   assign done          = doneReg;
   assign defective     = defReg;
   assign failAddr      = addrReg;
   assign busy          = (stateReg != ppp_pkg::PPP_IDLE);
endmodule // ppp_prom_programmer
`default_nettype wire

/* File: rtl/ppp_defines.svh */
// timing counts and codes for the prom programmer controller
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH

`define PPP_CLK_MHZ          125
`define PPP_PULSE_US         1000
`define PPP_PULSE_CYC        (`PPP_PULSE_US * `PPP_CLK_MHZ)
`define PPP_OVER_US          3000
`define PPP_OVER_CYC         (`PPP_OVER_US * `PPP_CLK_MHZ)
`define PPP_MAX_TRIES        25
`define PPP_SETTLE_CYC       16
`define PPP_LAST_ADDR        15'h7fff
`define PPP_ADDR_W           15
`define PPP_DATA_W           8

`endif

/* File: rtl/ppp_pkg.sv */
// types for the prom programmer controller
`default_nettype none
package ppp_pkg;
   typedef enum logic [3:0] {
      PPP_IDLE   = 4'b0000,
      PPP_PWRUP  = 4'b0001,
      PPP_SETUP  = 4'b0011,
      PPP_PULSE  = 4'b0010,
      PPP_VSET   = 4'b0110,
      PPP_VCHK   = 4'b0111,
      PPP_OVER   = 4'b0101,
      PPP_NEXT   = 4'b0100,
      PPP_RDSET  = 4'b1100,
      PPP_RDCAP  = 4'b1101,
      PPP_DONE   = 4'b1111,
      PPP_FAIL   = 4'b1110
   } ppp_state_t;

   typedef enum logic [1:0] {
      PPP_VPP_GND  = 2'b00,
      PPP_VPP_5V   = 2'b01,
      PPP_VPP_12V5 = 2'b10
   } ppp_vpp_t;

   typedef enum logic [1:0] {
      PPP_VDD_OFF = 2'b00,
      PPP_VDD_5V  = 2'b01,
      PPP_VDD_6V  = 2'b10
   } ppp_vdd_t;
endpackage
`default_nettype wire

/* File: rtl/ppp_image_mem.sv */
// image memory holding the bytes to be written into the prom
`default_nettype none
module ppp_image_mem #(
   parameter int ADDR_W = 15,
   parameter int DATA_W = 8
) (
   input  wire logic              core_clk,
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic [DATA_W-1:0] wrData,
   input  wire logic [ADDR_W-1:0] rdAddr,
   output logic      [DATA_W-1:0] rdData
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // registered read keeps the data output off a combinational path
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // ppp_image_mem
`default_nettype wire

/* File: bench/ppp_prom_model.sv */
// behavioural model of the programmable memory behind the pins
`default_nettype none
module ppp_prom_model #(
   parameter int ADDR_W = 15,
   parameter int WEAK   = 3,
   parameter int STUCK  = 5
) (
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              enable_n,
   input  wire logic              read_n,
   input  wire logic              reset_n,
   input  wire ppp_pkg::ppp_vpp_t vpp,
   input  wire ppp_pkg::ppp_vdd_t vdd,
   input  wire logic [7:0]        busIn,
   input  wire logic              stuckEn,
   output logic      [7:0]        dOut,
   output logic                   dOe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // cell array
   // ----------
   logic [7:0] mem [2**ADDR_W];
   logic [7:0] latched;
   logic       weakHit = 1'h0;
   wire  logic progMode = !reset_n && vpp != ppp_pkg::PPP_VPP_GND;
   wire  logic hiV = vpp == ppp_pkg::PPP_VPP_12V5 && vdd == ppp_pkg::PPP_VDD_6V;
   wire  logic wrMode = progMode && hiV && !enable_n && read_n;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // sample a little after the edge so the driver's enable has landed
   always @(posedge wrMode) #1 latched = busIn;
   // programming only clears bits; the weak cell ignores its first pulse
   always @(negedge wrMode) begin
      if (addr == ADDR_W'(WEAK) && !weakHit) weakHit = 1'h1;
      else mem[addr] = mem[addr] & latched;
   end
   assign dOut = mem[addr] ^ {7'h00, stuckEn && addr == ADDR_W'(STUCK)};
   // verify drives with enable high at raised supplies; read drives with enable low at 5 V
   assign dOe = progMode && !read_n && (hiV ? enable_n : !enable_n);
endmodule // ppp_prom_model
`default_nettype wire

/* File: bench/ppp_prom_programmer_props.sv */
// assertion checker for the prom programmer pins
`default_nettype none
module ppp_prom_programmer_props #(
   parameter int ADDR_W = 15
) (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              busy,
   input wire logic              done,
   input wire logic              defective,
   input wire logic              readValid,
   input wire logic [ADDR_W-1:0] prog_addr_bus,
   input wire logic              progDataOe,
   input wire logic              progEnable_n,
   input wire logic              progRead_n,
   input wire logic              devReset_n,
   input wire ppp_pkg::ppp_vpp_t vppSel,
   input wire ppp_pkg::ppp_vdd_t vddSel
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic hiV = vppSel == ppp_pkg::PPP_VPP_12V5;
   a_no_dual_low: assert property (hiV |-> progEnable_n || progRead_n)
      else $error("enable and read low at high voltage");
   a_hi_needs_vdd: assert property (hiV |-> vddSel == ppp_pkg::PPP_VDD_6V && !devReset_n)
      else $error("high voltage without 6 V supply");
   a_drive_in_pulse: assert property (progDataOe |-> !progEnable_n && progRead_n && hiV)
      else $error("data driven outside a write pulse");
   a_pulse_width: assert property ($fell(progEnable_n) && progDataOe |-> !progEnable_n [*8])
      else $error("program pulse too short");
   a_session_reset: assert property (vppSel != ppp_pkg::PPP_VPP_GND |-> !devReset_n)
      else $error("supply raised with reset high");
   a_read_supply: assert property (!progRead_n && !hiV |-> vppSel == ppp_pkg::PPP_VPP_5V
      && vddSel == ppp_pkg::PPP_VDD_5V && !devReset_n)
      else $error("read strobe outside read setup");
   a_addr_step: assert property (hiV && $past(hiV) && $changed(prog_addr_bus)
      |-> prog_addr_bus == $past(prog_addr_bus) + 1'h1 || prog_addr_bus == '0)
      else $error("address did not step by one");
   a_valid_pulse: assert property (readValid |=> !readValid)
      else $error("read valid longer than one cycle");
   a_flags_excl: assert property (!(done && defective))
      else $error("done and defective together");
   a_idle_safe: assert property (!busy ##1 !busy |-> devReset_n && vppSel == ppp_pkg::PPP_VPP_GND
      && progEnable_n && progRead_n && !progDataOe)
      else $error("pins not parked while idle");
endmodule // ppp_prom_programmer_props
bind ppp_prom_programmer ppp_prom_programmer_props #(.ADDR_W(ADDR_W)) props_i (.core_clk, .rst, .busy, .done,
   .defective, .readValid, .prog_addr_bus, .progDataOe, .progEnable_n, .progRead_n, .devReset_n, .vppSel, .vddSel);
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the prom programmer controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // environment
   // ----------
   localparam int AW = 8;
   localparam int PULSE = 8;
   localparam int OVER = 8;
   localparam int WEAK = 3;
   localparam int STUCK = 5;
   logic              core_clk = 1'h0;
   logic              rst = 1'h1;
   logic              imgWrEn = 1'h0, startProg = 1'h0, startRead = 1'h0, stuckEn = 1'h0;
   logic [AW-1:0]     imgWrAddr = '0, readAddr = '0, failAddr, prog_addr_bus;
   logic [7:0]        imgWrData = '0, readData, progDataOut, dOut, bus, lastBus = '0;
   logic              readValid, busy, done, defective, progDataOe, progEnable_n, progRead_n, devReset_n, dOe;
   ppp_pkg::ppp_vpp_t vppSel;
   ppp_pkg::ppp_vdd_t vddSel;
   int                n_errors = 0, cmp_count = 0, pw = 0, pAddr = 0, nStuck = 0;
   int                widths[$];
   always #4 core_clk = ~core_clk;
   // a released bus shows the inverse of its last value, never a kind guess
   assign bus = progDataOe ? progDataOut : (dOe ? dOut : ~lastBus);
   always @(posedge core_clk) begin
      if (progDataOe || dOe) lastBus <= bus;
      if (!progEnable_n && progDataOe) begin
         pw++;
         pAddr = prog_addr_bus;
      end else if (pw != 0) begin
         if (pAddr == WEAK) widths.push_back(pw);
         if (pAddr == STUCK && pw == PULSE) nStuck++;
         pw = 0;
      end
   end
   ppp_prom_programmer #(.ADDR_W(AW), .PULSE_CYC(PULSE), .OVER_CYC(OVER), .SETTLE_CYC(4)) ppp_prom_programmer_i (
      .core_clk, .rst, .imgWrEn, .imgWrAddr, .imgWrData, .startProg, .startRead, .readAddr, .readData, .readValid,
      .busy, .done, .defective, .failAddr, .prog_addr_bus, .progDataIn(bus), .progDataOut, .progDataOe,
      .progEnable_n, .progRead_n, .devReset_n, .vppSel, .vddSel);
   ppp_prom_model #(.ADDR_W(AW), .WEAK(WEAK), .STUCK(STUCK)) ppp_prom_model_i (.addr(prog_addr_bus),
      .enable_n(progEnable_n), .read_n(progRead_n), .reset_n(devReset_n), .vpp(vppSel), .vdd(vddSel),
      .busIn(bus), .stuckEn, .dOut, .dOe);
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'h1) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   function automatic logic [7:0] img(input int a);
      return 8'(a) ^ 8'h5a;
   endfunction
   task automatic run_prog();
      int k;
      k = 0;
      startProg = 1'h1;
      tick(1);
      startProg = 1'h0;
      while (busy !== 1'h0 && k < 20000) begin
         tick(1);
         k++;
      end
      chk(k < 20000, "program run hung");
   endtask
   task automatic test_reset();
      chk(devReset_n === 1'h1 && vppSel === ppp_pkg::PPP_VPP_GND && vddSel === ppp_pkg::PPP_VDD_OFF
         && progEnable_n === 1'h1 && progRead_n === 1'h1 && progDataOe === 1'h0 && busy === 1'h0
         && done === 1'h0 && defective === 1'h0, "pins after reset");
   endtask
   task automatic test_program();
      for (int a = 0; a < 2**AW; a++) begin
         imgWrEn = 1'h1;
         imgWrAddr = AW'(a);
         imgWrData = img(a);
         tick(1);
      end
      imgWrEn = 1'h0;
      run_prog();
      chk(done === 1'h1 && defective === 1'h0, "program flags");
      chk(widths.size() == 3 && widths[0] == PULSE && widths[1] == PULSE && widths[2] == 2 * OVER, "retry pulses");
      for (int a = 0; a < 2**AW; a++) chk(ppp_prom_model_i.mem[a] === img(a), "cell content");
   endtask
   task automatic test_read();
      int addrs[3] = '{0, WEAK, 2**AW - 1};
      int k;
      foreach (addrs[i]) begin
         readAddr = AW'(addrs[i]);
         startRead = 1'h1;
         tick(1);
         startRead = 0;
         k = 0;
         while (readValid !== 1'h1 && k < 100) begin
            tick(1);
            k++;
         end
         chk(readData === img(addrs[i]), "read back byte");
      end
   endtask
   task automatic test_defect();
      stuckEn = 1'h1;
      nStuck = 0;
      run_prog();
      chk(defective === 1'h1 && done === 1'h0 && failAddr === AW'(STUCK), "defect flags");
      chk(nStuck == 25, "attempts on failing byte");
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      tick(8);
      rst = 1'h0;
      tick(1);
      test_reset();
      test_program();
      test_read();
      test_defect();
      complete_run();
   end
   initial begin
      #400000;
      n_errors++;
      complete_run();
   end
endmodule // testbench
`default_nettype wire
